/* File: srp_pkg.sv */
package srp_pkg;

  ////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0] SRP_IDX_VCO_OVERRIDE_CONTROL = 8'h08;
  localparam logic [7:0] SRP_IDX_REFERENCE_PATH_CONTROL = 8'h09;
  localparam logic [7:0] SRP_IDX_REFERENCE_MULTIPLIER = 8'h0a;
  localparam logic [7:0] SRP_IDX_POST_MULTIPLIER_DIVIDER = 8'h0b;
  localparam logic [7:0] SRP_IDX_PRE_MULTIPLIER_DIVIDER = 8'h0c;
  localparam logic [7:0] SRP_IDX_PUMP_AND_DETECTOR_CONTROL = 8'h0d;
  localparam logic [7:0] SRP_IDX_PUMP_CURRENT_SETTING = 8'h0e;
  localparam logic [7:0] SRP_IDX_VCO_AMPLITUDE_CODE = 8'h13;
  localparam logic [7:0] SRP_IDX_CAPBANK_CODE = 8'h16;
  localparam logic [7:0] SRP_IDX_CORE_SELECT = 8'h17;

  ////////////////////////////////////////////////////////////////
  // reset values, unnamed bits reset to zero
  localparam logic [15:0] SRP_RST_VCO_OVERRIDE_CONTROL = 16'h0000;
  localparam logic [15:0] SRP_RST_REFERENCE_PATH_CONTROL = 16'h0200;
  localparam logic [15:0] SRP_RST_REFERENCE_MULTIPLIER = 16'h0080;
  localparam logic [15:0] SRP_RST_POST_MULTIPLIER_DIVIDER = 16'h0010;
  localparam logic [15:0] SRP_RST_PRE_MULTIPLIER_DIVIDER = 16'h0001;
  localparam logic [15:0] SRP_RST_PUMP_AND_DETECTOR_CONTROL = 16'h4000;
  localparam logic [15:0] SRP_RST_PUMP_CURRENT_SETTING = 16'h018d;
  localparam logic [15:0] SRP_RST_VCO_AMPLITUDE_CODE = 16'h0960;
  localparam logic [15:0] SRP_RST_CAPBANK_CODE = 16'h0000;
  localparam logic [15:0] SRP_RST_CORE_SELECT = 16'h0800;

  ////////////////////////////////////////////////////////////////
  // field positions
  localparam int SRP_POS_AMPLITUDE_OVERRIDE = 13;
  localparam int SRP_POS_CAPBANK_OVERRIDE = 10;
  localparam int SRP_POS_DOUBLER_ENABLE = 11;
  localparam int SRP_POS_REFERENCE_ENABLE = 9;
  localparam int SRP_POS_REFERENCE_MULTIPLIER_FACTOR_LSB = 7;
  localparam int SRP_POS_POST_DIV_LSB = 4;
  localparam int SRP_POS_PRE_DIV_LSB = 0;
  localparam int SRP_POS_PUMP_ENABLE = 14;
  localparam int SRP_POS_DETECTOR_MODE_LSB = 8;
  localparam int SRP_POS_PUMP_DOWN_LSB = 7;
  localparam int SRP_POS_PUMP_UP_LSB = 2;
  localparam int SRP_POS_PUMP_GAIN_LSB = 0;
  localparam int SRP_POS_AMPLITUDE_CODE_LSB = 3;
  localparam int SRP_POS_CAPBANK_CODE_LSB = 0;
  localparam int SRP_POS_CORE_SELECT_LSB = 11;
  localparam int SRP_POS_CORE_FORCE = 10;

  localparam logic [1:0] SRP_DETECTOR_SINGLE = 2'h3;

  ////////////////////////////////////////////////////////////////
  // pump current weights in microamps, gain in halves
  localparam logic [12:0] SRP_UA_BIT4 = 13'h04e2;
  localparam logic [12:0] SRP_UA_BIT3 = 13'h09c4;
  localparam logic [12:0] SRP_UA_BIT2 = 13'h0271;
  localparam logic [12:0] SRP_UA_BIT1 = 13'h0138;
  localparam logic [12:0] SRP_UA_BIT0 = 13'h009c;
  localparam logic [2:0] SRP_GAIN_HALVES_0 = 3'h2;
  localparam logic [2:0] SRP_GAIN_HALVES_1 = 3'h4;
  localparam logic [2:0] SRP_GAIN_HALVES_2 = 3'h3;
  localparam logic [2:0] SRP_GAIN_HALVES_3 = 3'h5;

  ////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [15:0] vco_override_control;
    logic [15:0] reference_path_control;
    logic [15:0] reference_multiplier;
    logic [15:0] post_multiplier_divider;
    logic [15:0] pre_multiplier_divider;
    logic [15:0] pump_and_detector_control;
    logic [15:0] pump_current_setting;
    logic [15:0] vco_amplitude_code;
    logic [15:0] capbank_code;
    logic [15:0] core_select;
  } srp_regs_t;

  typedef struct packed {
    logic [8:0] amplitude;
    logic amplitude_cal_bypass;
    logic [7:0] capbank;
    logic frequency_cal_bypass;
    logic [2:0] core;
  } srp_vco_ctl_t;

  typedef struct packed {
    srp_regs_t regs;
    srp_vco_ctl_t vco;
    logic [31:0] prdata;
    logic pslverr;
  } srp_state_t;

  typedef struct packed {
    logic [15:0] current_ua;
  } srp_calc_state_t;

endpackage

/* File: srp_pump_calc.sv */
`timescale 1ns/100ps
`default_nettype none

module srp_pump_calc
  import srp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] current_bits_in,
  input wire logic [1:0] gain_in,
  output logic [15:0] current_ua_out
);

  srp_calc_state_t state_reg;
  srp_calc_state_t state_next;
  logic [12:0] base_ua;
  logic [2:0] halves;
  logic [15:0] scaled;

  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    base_ua = 13'h0000;
    if (current_bits_in[4])
      base_ua = base_ua + SRP_UA_BIT4;
    if (current_bits_in[3])
      base_ua = base_ua + SRP_UA_BIT3;
    if (current_bits_in[2])
      base_ua = base_ua + SRP_UA_BIT2;
    if (current_bits_in[1])
      base_ua = base_ua + SRP_UA_BIT1;
    if (current_bits_in[0])
      base_ua = base_ua + SRP_UA_BIT0;
    case (gain_in)
      2'h0: halves = SRP_GAIN_HALVES_0;
      2'h1: halves = SRP_GAIN_HALVES_1;
      2'h2: halves = SRP_GAIN_HALVES_2;
      default: halves = SRP_GAIN_HALVES_3;
    endcase
    // gain kept in halves so 1.5 and 2.5 stay integer
    scaled = 16'({3'h0, base_ua} * {13'h0000, halves});
    state_next = state_reg;
    state_next.current_ua = {1'b0, scaled[15:1]};
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign current_ua_out = state_reg.current_ua;

endmodule

`default_nettype wire

/* File: srp_regs.sv */
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - amplitude override bit 13 bypasses amplitude calibration, uses programmed code.
// - amplitude code in bits 11:3, resets to 300, applied only under override.
// - capbank override bit 10 bypasses frequency calibration, uses programmed capbank code.
// - reference multiplier factor bits 11:7, reset 1, 40-70 MHz to 180-250 MHz.
// - post-multiplier divide ratio bits 11:4, reset 1, feeds phase detector.
// - pre-multiplier divide ratio bits 11:0, reset 1, after doubler.
// - detector mode bits 9:8, 0 dual at reset, 3 single above 200MHz.
// - each pump current bit adds a fixed weighted current.
// - pump gain bits 1:0 scale current by 1, 2, 1.5, 2.5; reset 1.
module srp_regs
  import srp_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic [8:0] auto_amplitude_in,
  input wire logic [7:0] auto_capbank_in,
  input wire logic [2:0] auto_core_in,
  output logic [8:0] vco_amplitude_out,
  output logic amplitude_cal_bypass_out,
  output logic [7:0] vco_capbank_out,
  output logic frequency_cal_bypass_out,
  output logic [2:0] vco_core_out,
  output logic reference_doubler_enable_out,
  output logic reference_enable_out,
  output logic [4:0] reference_multiplier_factor_out,
  output logic [7:0] post_divide_ratio_out,
  output logic [11:0] pre_divide_ratio_out,
  output logic pump_enable_out,
  output logic [1:0] detector_mode_out,
  output logic detector_single_out,
  output logic [4:0] pump_down_current_out,
  output logic [4:0] pump_up_current_out,
  output logic [1:0] pump_gain_out,
  output logic [15:0] pump_down_ua_out,
  output logic [15:0] pump_up_ua_out
);

  ////////////////////////////////////////////////////////////////
  // the highest index needs seven byte-address bits
  if (ADDR_W < 7 || ADDR_W > 32)
  begin
    $error("srp_regs: ADDR_W must lie between 7 and 32");
  end

  ////////////////////////////////////////////////////////////////
  // word index from byte address; misaligned maps to nothing
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
    logic [31:0] wide;
    wide = 32'(addr);
    if (wide[1:0] != 2'h0 || wide[31:10] != 22'h000000)
      word_index = 8'hff;
    else
      word_index = wide[9:2];
  endfunction

  function automatic logic index_mapped(input logic [7:0] idx);
    case (idx)
      SRP_IDX_VCO_OVERRIDE_CONTROL,
      SRP_IDX_REFERENCE_PATH_CONTROL,
      SRP_IDX_REFERENCE_MULTIPLIER,
      SRP_IDX_POST_MULTIPLIER_DIVIDER,
      SRP_IDX_PRE_MULTIPLIER_DIVIDER,
      SRP_IDX_PUMP_AND_DETECTOR_CONTROL,
      SRP_IDX_PUMP_CURRENT_SETTING,
      SRP_IDX_VCO_AMPLITUDE_CODE,
      SRP_IDX_CAPBANK_CODE,
      SRP_IDX_CORE_SELECT: index_mapped = 1'b1;
      default: index_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] read_word(input srp_regs_t r, input logic [7:0] idx);
    case (idx)
      SRP_IDX_VCO_OVERRIDE_CONTROL: read_word = r.vco_override_control;
      SRP_IDX_REFERENCE_PATH_CONTROL: read_word = r.reference_path_control;
      SRP_IDX_REFERENCE_MULTIPLIER: read_word = r.reference_multiplier;
      SRP_IDX_POST_MULTIPLIER_DIVIDER: read_word = r.post_multiplier_divider;
      SRP_IDX_PRE_MULTIPLIER_DIVIDER: read_word = r.pre_multiplier_divider;
      SRP_IDX_PUMP_AND_DETECTOR_CONTROL: read_word = r.pump_and_detector_control;
      SRP_IDX_PUMP_CURRENT_SETTING: read_word = r.pump_current_setting;
      SRP_IDX_VCO_AMPLITUDE_CODE: read_word = r.vco_amplitude_code;
      SRP_IDX_CAPBANK_CODE: read_word = r.capbank_code;
      SRP_IDX_CORE_SELECT: read_word = r.core_select;
      default: read_word = 16'h0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  srp_state_t state_reg;
  srp_state_t state_next;
  logic [7:0] req_index;
  logic setup_phase;
  logic access_write;
  logic amplitude_override;
  logic capbank_override;
  logic core_force;
  logic [8:0] amplitude_code;
  logic [7:0] capbank_code;
  logic [2:0] core_select;

  assign req_index = word_index(paddr_in);
  assign setup_phase = psel_in && !penable_in;
  // zero-wait access phase; write lands on this edge only
  assign access_write = psel_in && penable_in && pwrite_in && index_mapped(req_index);

  assign amplitude_override = state_reg.regs.vco_override_control[SRP_POS_AMPLITUDE_OVERRIDE];
  assign capbank_override = state_reg.regs.vco_override_control[SRP_POS_CAPBANK_OVERRIDE];
  assign core_force = state_reg.regs.core_select[SRP_POS_CORE_FORCE];
  assign amplitude_code = state_reg.regs.vco_amplitude_code[SRP_POS_AMPLITUDE_CODE_LSB +: 9];
  assign capbank_code = state_reg.regs.capbank_code[SRP_POS_CAPBANK_CODE_LSB +: 8];
  assign core_select = state_reg.regs.core_select[SRP_POS_CORE_SELECT_LSB +: 3];

  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    // read data and error latched in setup so outputs come from flops
    if (setup_phase)
    begin
      state_next.pslverr = !index_mapped(req_index);
      if (!pwrite_in)
        state_next.prdata = {16'h0000, read_word(state_reg.regs, req_index)};
      else
        state_next.prdata = 32'h00000000;
    end
    // all sixteen bits stored so software can restore map defaults
    if (access_write)
    begin
      case (req_index)
        SRP_IDX_VCO_OVERRIDE_CONTROL: state_next.regs.vco_override_control = pwdata_in[15:0];
        SRP_IDX_REFERENCE_PATH_CONTROL: state_next.regs.reference_path_control = pwdata_in[15:0];
        SRP_IDX_REFERENCE_MULTIPLIER: state_next.regs.reference_multiplier = pwdata_in[15:0];
        SRP_IDX_POST_MULTIPLIER_DIVIDER: state_next.regs.post_multiplier_divider = pwdata_in[15:0];
        SRP_IDX_PRE_MULTIPLIER_DIVIDER: state_next.regs.pre_multiplier_divider = pwdata_in[15:0];
        SRP_IDX_PUMP_AND_DETECTOR_CONTROL: state_next.regs.pump_and_detector_control = pwdata_in[15:0];
        SRP_IDX_PUMP_CURRENT_SETTING: state_next.regs.pump_current_setting = pwdata_in[15:0];
        SRP_IDX_VCO_AMPLITUDE_CODE: state_next.regs.vco_amplitude_code = pwdata_in[15:0];
        SRP_IDX_CAPBANK_CODE: state_next.regs.capbank_code = pwdata_in[15:0];
        SRP_IDX_CORE_SELECT: state_next.regs.core_select = pwdata_in[15:0];
        default: state_next.regs = state_reg.regs;
      endcase
    end
    state_next.vco.amplitude_cal_bypass = amplitude_override;
    // programmed amplitude only while override set
    // range 250..450 left to software, not clamped here
    if (amplitude_override)
      state_next.vco.amplitude = amplitude_code;
    else
      state_next.vco.amplitude = auto_amplitude_in;
    state_next.vco.frequency_cal_bypass = capbank_override;
    if (capbank_override)
      state_next.vco.capbank = capbank_code;
    else
      state_next.vco.capbank = auto_capbank_in;
    // manual core only with force; core 0 is not checked
    if (capbank_override && core_force)
      state_next.vco.core = core_select;
    else
      state_next.vco.core = auto_core_in;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg.regs.vco_override_control <= SRP_RST_VCO_OVERRIDE_CONTROL;
      state_reg.regs.reference_path_control <= SRP_RST_REFERENCE_PATH_CONTROL;
      state_reg.regs.reference_multiplier <= SRP_RST_REFERENCE_MULTIPLIER;
      state_reg.regs.post_multiplier_divider <= SRP_RST_POST_MULTIPLIER_DIVIDER;
      state_reg.regs.pre_multiplier_divider <= SRP_RST_PRE_MULTIPLIER_DIVIDER;
      state_reg.regs.pump_and_detector_control <= SRP_RST_PUMP_AND_DETECTOR_CONTROL;
      state_reg.regs.pump_current_setting <= SRP_RST_PUMP_CURRENT_SETTING;
      state_reg.regs.vco_amplitude_code <= SRP_RST_VCO_AMPLITUDE_CODE;
      state_reg.regs.capbank_code <= SRP_RST_CAPBANK_CODE;
      state_reg.regs.core_select <= SRP_RST_CORE_SELECT;
      state_reg.vco <= '0;
      state_reg.prdata <= 32'h00000000;
      state_reg.pslverr <= 1'b0;
    end
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////
  // weighted current per pump direction
  srp_pump_calc u_down_calc (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .current_bits_in(state_reg.regs.pump_current_setting[SRP_POS_PUMP_DOWN_LSB +: 5]),
    .gain_in(state_reg.regs.pump_current_setting[SRP_POS_PUMP_GAIN_LSB +: 2]),
    .current_ua_out(pump_down_ua_out)
  );

  srp_pump_calc u_up_calc (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .current_bits_in(state_reg.regs.pump_current_setting[SRP_POS_PUMP_UP_LSB +: 5]),
    .gain_in(state_reg.regs.pump_current_setting[SRP_POS_PUMP_GAIN_LSB +: 2]),
    .current_ua_out(pump_up_ua_out)
  );

  ////////////////////////////////////////////////////////////////
  assign pready_out = 1'b1;
  assign prdata_out = state_reg.prdata;
  assign pslverr_out = state_reg.pslverr;

  assign vco_amplitude_out = state_reg.vco.amplitude;
  assign amplitude_cal_bypass_out = state_reg.vco.amplitude_cal_bypass;
  assign vco_capbank_out = state_reg.vco.capbank;
  assign frequency_cal_bypass_out = state_reg.vco.frequency_cal_bypass;
  assign vco_core_out = state_reg.vco.core;

  assign reference_doubler_enable_out = state_reg.regs.reference_path_control[SRP_POS_DOUBLER_ENABLE];
  assign reference_enable_out = state_reg.regs.reference_path_control[SRP_POS_REFERENCE_ENABLE];
  assign reference_multiplier_factor_out = state_reg.regs.reference_multiplier[SRP_POS_REFERENCE_MULTIPLIER_FACTOR_LSB +: 5];
  assign post_divide_ratio_out = state_reg.regs.post_multiplier_divider[SRP_POS_POST_DIV_LSB +: 8];
  assign pre_divide_ratio_out = state_reg.regs.pre_multiplier_divider[SRP_POS_PRE_DIV_LSB +: 12];
  assign pump_enable_out = state_reg.regs.pump_and_detector_control[SRP_POS_PUMP_ENABLE];
  assign detector_mode_out = state_reg.regs.pump_and_detector_control[SRP_POS_DETECTOR_MODE_LSB +: 2];
  assign detector_single_out = (detector_mode_out == SRP_DETECTOR_SINGLE);
  // fields exposed raw; equality is software's duty
  assign pump_down_current_out = state_reg.regs.pump_current_setting[SRP_POS_PUMP_DOWN_LSB +: 5];
  assign pump_up_current_out = state_reg.regs.pump_current_setting[SRP_POS_PUMP_UP_LSB +: 5];
  assign pump_gain_out = state_reg.regs.pump_current_setting[SRP_POS_PUMP_GAIN_LSB +: 2];

endmodule

`default_nettype wire

/* File: srp_regs_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module srp_regs_asserts
  import srp_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic [8:0] auto_amplitude_in,
  input wire logic [7:0] auto_capbank_in,
  input wire logic [2:0] auto_core_in,
  input wire logic [8:0] vco_amplitude_out,
  input wire logic amplitude_cal_bypass_out,
  input wire logic [7:0] vco_capbank_out,
  input wire logic frequency_cal_bypass_out,
  input wire logic [2:0] vco_core_out,
  input wire logic [4:0] reference_multiplier_factor_out,
  input wire logic [7:0] post_divide_ratio_out,
  input wire logic [1:0] detector_mode_out,
  input wire logic detector_single_out,
  input wire logic [4:0] pump_down_current_out,
  input wire logic [4:0] pump_up_current_out,
  input wire logic [1:0] pump_gain_out,
  input wire logic [15:0] pump_down_ua_out,
  input wire logic [15:0] pump_up_ua_out
);
  ////////////////////////////////////////////////////////////////
  logic acc_wr;
  assign acc_wr = psel_in && penable_in && pwrite_in && pready_out;
  // gain in halves so 1.5 and 2.5 stay integer
  function automatic logic [15:0] ua_of(input logic [4:0] b, input logic [1:0] g);
    int s;
    s = (b[4] ? 1250 : 0) + (b[3] ? 2500 : 0) + (b[2] ? 625 : 0) + (b[1] ? 312 : 0) + (b[0] ? 156 : 0);
    s = s * (g == 2'h0 ? 2 : g == 2'h1 ? 4 : g == 2'h2 ? 3 : 5);
    return 16'(s >> 1);
  endfunction
  function automatic logic [ADDR_W-1:0] adr(input logic [7:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////
  AST_AMP_AUTO:
    assert property ($past(rst_n_in) && !amplitude_cal_bypass_out |-> vco_amplitude_out == $past(auto_amplitude_in))
    else $error("amplitude not from calibration");
  AST_AMP_BYPASS:
    assert property (acc_wr && paddr_in == adr(SRP_IDX_VCO_OVERRIDE_CONTROL)
      |=> ##1 amplitude_cal_bypass_out == $past(pwdata_in[13], 2)) else $error("amplitude bypass wrong");
  AST_CAP_BYPASS:
    assert property (acc_wr && paddr_in == adr(SRP_IDX_VCO_OVERRIDE_CONTROL)
      |=> ##1 frequency_cal_bypass_out == $past(pwdata_in[10], 2)) else $error("capbank bypass wrong");
  AST_CAP_AUTO:
    assert property ($past(rst_n_in) && !frequency_cal_bypass_out |-> vco_capbank_out == $past(auto_capbank_in)
      && vco_core_out == $past(auto_core_in)) else $error("capbank not from calibration");
  AST_REFERENCE_MULTIPLIER_FACTOR_WR:
    assert property (acc_wr && paddr_in == adr(SRP_IDX_REFERENCE_MULTIPLIER)
      |=> reference_multiplier_factor_out == $past(pwdata_in[11:7])) else $error("multiplier field wrong");
  AST_POST_WR:
    assert property (acc_wr && paddr_in == adr(SRP_IDX_POST_MULTIPLIER_DIVIDER)
      |=> post_divide_ratio_out == $past(pwdata_in[11:4])) else $error("post divider field wrong");
  AST_MODE_WR:
    assert property (acc_wr && paddr_in == adr(SRP_IDX_PUMP_AND_DETECTOR_CONTROL) |=> detector_mode_out ==
      $past(pwdata_in[9:8]) && detector_single_out == ($past(pwdata_in[9:8]) == 2'h3)) else $error("mode wrong");
  AST_GAIN_WR:
    assert property (acc_wr && paddr_in == adr(SRP_IDX_PUMP_CURRENT_SETTING)
      |=> pump_gain_out == $past(pwdata_in[1:0])) else $error("gain field wrong");
  AST_CUR_WR:
    assert property (acc_wr && paddr_in == adr(SRP_IDX_PUMP_CURRENT_SETTING) |=> pump_down_current_out ==
      $past(pwdata_in[11:7]) && pump_up_current_out == $past(pwdata_in[6:2])) else $error("current fields wrong");
  AST_DN_UA:
    assert property ($past(rst_n_in) |-> pump_down_ua_out == ua_of($past(pump_down_current_out), $past(pump_gain_out)))
    else $error("down current value wrong");
  AST_UP_UA:
    assert property ($past(rst_n_in) |-> pump_up_ua_out == ua_of($past(pump_up_current_out), $past(pump_gain_out)))
    else $error("up current value wrong");
endmodule

bind srp_regs srp_regs_asserts #(.ADDR_W(ADDR_W)) u_asserts (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pready_out(pready_out), .auto_amplitude_in(auto_amplitude_in), .auto_capbank_in(auto_capbank_in),
  .auto_core_in(auto_core_in), .vco_amplitude_out(vco_amplitude_out), .vco_capbank_out(vco_capbank_out),
  .amplitude_cal_bypass_out(amplitude_cal_bypass_out), .frequency_cal_bypass_out(frequency_cal_bypass_out),
  .vco_core_out(vco_core_out), .reference_multiplier_factor_out(reference_multiplier_factor_out),
  .post_divide_ratio_out(post_divide_ratio_out), .detector_mode_out(detector_mode_out),
  .detector_single_out(detector_single_out), .pump_down_current_out(pump_down_current_out),
  .pump_up_current_out(pump_up_current_out), .pump_gain_out(pump_gain_out),
  .pump_down_ua_out(pump_down_ua_out), .pump_up_ua_out(pump_up_ua_out));
`default_nettype wire

/* File: test_synth_ref_path_cp_vco_override_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module test_synth_ref_path_cp_vco_override_regs
  import srp_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [8:0] auto_amp = 9'h000;
  logic [7:0] auto_cap = 8'h00;
  logic [2:0] auto_core = 3'h0;
  logic pready, pslverr, amp_byp, frq_byp, dbl_en, ref_en, pump_en, single;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic e;
  logic [8:0] vco_amp;
  logic [7:0] vco_cap, post_div;
  logic [2:0] vco_core;
  logic [4:0] reference_multiplier_factor, dn_cur, up_cur;
  logic [11:0] pre_div;
  logic [1:0] mode, gain;
  logic [15:0] dn_ua, up_ua;
  int failures = 0;
  int checks = 0;
  logic [15:0] mdl [logic [7:0]];
  logic [7:0] idxs [10] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h13, 8'h16, 8'h17};
  logic [15:0] rsts [10] = '{SRP_RST_VCO_OVERRIDE_CONTROL, SRP_RST_REFERENCE_PATH_CONTROL,
    SRP_RST_REFERENCE_MULTIPLIER, SRP_RST_POST_MULTIPLIER_DIVIDER, SRP_RST_PRE_MULTIPLIER_DIVIDER,
    SRP_RST_PUMP_AND_DETECTOR_CONTROL, SRP_RST_PUMP_CURRENT_SETTING, SRP_RST_VCO_AMPLITUDE_CODE,
    SRP_RST_CAPBANK_CODE, SRP_RST_CORE_SELECT};

  always #20 ref_clk_in = ~ref_clk_in;

  srp_regs dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .auto_amplitude_in(auto_amp), .auto_capbank_in(auto_cap), .auto_core_in(auto_core),
    .vco_amplitude_out(vco_amp), .amplitude_cal_bypass_out(amp_byp), .vco_capbank_out(vco_cap),
    .frequency_cal_bypass_out(frq_byp), .vco_core_out(vco_core), .reference_doubler_enable_out(dbl_en),
    .reference_enable_out(ref_en), .reference_multiplier_factor_out(reference_multiplier_factor), .post_divide_ratio_out(post_div),
    .pre_divide_ratio_out(pre_div), .pump_enable_out(pump_en), .detector_mode_out(mode),
    .detector_single_out(single), .pump_down_current_out(dn_cur), .pump_up_current_out(up_cur),
    .pump_gain_out(gain), .pump_down_ua_out(dn_ua), .pump_up_ua_out(up_ua));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] ua(input logic [4:0] b, input logic [1:0] g);
    int s;
    s = (b[4] ? 1250 : 0) + (b[3] ? 2500 : 0) + (b[2] ? 625 : 0) + (b[1] ? 312 : 0) + (b[0] ? 156 : 0);
    s = s * (g == 2'h0 ? 2 : g == 2'h1 ? 4 : g == 2'h2 ? 3 : 5);
    return 16'(s >> 1);
  endfunction
  function automatic logic [15:0] legal(input logic [7:0] idx);
    logic [4:0] c;
    c = 5'($urandom());
    case (idx)
      8'h08: return {2'h0, 1'($urandom()), 2'h0, 1'($urandom()), 10'h0};
      8'h09: return {4'h0, 1'($urandom()), 1'b0, 1'($urandom()), 9'h0};
      8'h0a: return {4'h0, 5'($urandom()), 7'h0};
      8'h0b: return {4'h0, 8'($urandom()), 4'h0};
      8'h0c: return {4'h0, 12'($urandom())};
      8'h0d: return {1'b0, 1'($urandom()), 4'h0, ($urandom() % 2 == 0) ? 2'h0 : 2'h3, 8'h0};
      8'h0e: return {4'h0, c, c, 2'($urandom())};
      8'h13: return {4'h0, 9'(250 + $urandom() % 201), 3'h0};
      8'h16: return {8'h0, 8'($urandom() % 184)};
      default: return {2'h0, 3'(1 + $urandom() % 7), 1'b1, 10'h0};
    endcase
  endfunction
  // request held until pready is seen; release left to the next call or idle
  task automatic apb(input logic w, input logic [7:0] idx, input logic [15:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {16'($urandom()), d};
    @(posedge ref_clk_in);
    penable <= 1'b1;
    @(posedge ref_clk_in);
    while (pready !== 1'b1)
      @(posedge ref_clk_in);
    rdat = prdata;
    e = pslverr;
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    auto_amp <= 9'($urandom());
    auto_cap <= 8'($urandom());
    auto_core <= 3'($urandom());
    apb(1'b1, idx, d);
    if (mdl.exists(idx))
      mdl[idx] = d;
  endtask
  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 16'h0);
    chk("rdata", rdat, mdl.exists(idx) ? {16'h0, mdl[idx]} : 32'h0);
    chk("pslverr", 32'(e), 32'(!mdl.exists(idx)));
  endtask
  task automatic settle();
    logic [15:0] o;
    o = mdl[8'h08];
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk("vco_amp", 32'(vco_amp), 32'(o[13] ? mdl[8'h13][11:3] : auto_amp));
    chk("amp_byp", 32'(amp_byp), 32'(o[13]));
    chk("frq_byp", 32'(frq_byp), 32'(o[10]));
    chk("vco_cap", 32'(vco_cap), 32'(o[10] ? mdl[8'h16][7:0] : auto_cap));
    chk("vco_core", 32'(vco_core), 32'(o[10] && mdl[8'h17][10] ? mdl[8'h17][13:11] : auto_core));
    chk("ref_ctl", 32'({dbl_en, ref_en, pump_en}), 32'({mdl[8'h09][11], mdl[8'h09][9], mdl[8'h0d][14]}));
    chk("reference_multiplier_factor", 32'(reference_multiplier_factor), 32'(mdl[8'h0a][11:7]));
    chk("post_div", 32'(post_div), 32'(mdl[8'h0b][11:4]));
    chk("pre_div", 32'(pre_div), 32'(mdl[8'h0c][11:0]));
    chk("mode", 32'({single, mode}), 32'({mdl[8'h0d][9:8] == 2'h3, mdl[8'h0d][9:8]}));
    chk("currents", 32'({dn_cur, up_cur, gain}), 32'(mdl[8'h0e][11:0]));
    chk("dn_ua", 32'(dn_ua), 32'(ua(mdl[8'h0e][11:7], mdl[8'h0e][1:0])));
    chk("up_ua", 32'(up_ua), 32'(ua(mdl[8'h0e][6:2], mdl[8'h0e][1:0])));
    @(posedge ref_clk_in);
  endtask
  task automatic read_all();
    for (int i = 0; i < 10; i++)
      rd(idxs[i]);
    idle();
  endtask
  task automatic results();
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h0624));
    for (int i = 0; i < 10; i++)
      mdl[idxs[i]] = rsts[i];
    repeat (16) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    read_all();
    chk("amp_rst", 32'(mdl[8'h13][11:3]), 32'd300);
    chk("field_rst", 32'({reference_multiplier_factor, post_div, pre_div}), 32'({5'h01, 8'h01, 12'h001}));
    chk("pump_rst", 32'({mode, dn_cur, up_cur, gain}), 32'({2'h0, 5'h03, 5'h03, 2'h1}));
    settle();
    // back-to-back legal writes, checked in batches of four
    for (int k = 0; k < 40; k++)
    begin
      wr(idxs[k % 10], legal(idxs[k % 10]));
      if (k % 4 == 3)
      begin
        idle();
        settle();
      end
    end
    // every single current bit with every gain code
    for (int i = 0; i < 20; i++)
    begin
      wr(8'h0e, {4'h0, 5'h01 << (i / 4), 5'h01 << (i / 4), 2'(i)});
      idle();
      settle();
    end
    // override and force combinations
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h08, {2'h0, 1'(i), 2'h0, 1'(i >> 1), 10'h0});
      wr(8'h17, {2'h0, 3'(i % 7 + 1), 1'(i >> 2), 10'h0});
      idle();
      settle();
    end
    // unmapped place refuses the write and reads as zero
    apb(1'b1, 8'h20, 16'hffff);
    chk("unmapped_err", 32'(e), 32'h1);
    rd(8'h20);
    read_all();
    results();
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk_in);
    failures++;
    results();
  end
endmodule
`default_nettype wire
